// [design/irq_dev.sv]
`timescale 1ns/1ps
`default_nettype none
module irq_dev
  import irq_pkg::*;
#(
  parameter int PULSE_LEN = PULSE_CYCLES
) (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            ce,
  input  wire logic [PINS-1:0] pin_event,
  input  wire logic [7:0]      src_event,
  irq_link_if.device           link
);

  // ---------------------------------------------------------------
  // link access decode
  // ---------------------------------------------------------------
  logic            ack_q;
  logic [7:0]      rdata_q;
  logic            take;
  logic            wr;
  logic [SRCS-1:0] main_en_q;
  logic [PINS-1:0] pin_en_q;
  logic [2:0]      icr_q;
  logic [SRCS-1:0] main_stat;
  logic [PINS-1:0] pin_stat;
  logic [SRCS-1:0] main_set;
  logic [SRCS-1:0] main_clr;
  logic [PINS-1:0] pin_clr;
  logic            gpio_hit;
  logic            pending;
  logic            active;
  logic            trig;
  logic [3:0]      pulse_cnt_q;
  logic            irq_q;
  logic            assert_lvl;

  // one request per ack; a held request is not taken twice
  assign take = ce & link.req & ~ack_q;
  assign wr   = take & link.we;

  // ---------------------------------------------------------------
  // enable and control registers
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_en_q <= MAIN_EN_RST;
    end else if (wr) begin
      if (link.addr == A_MAIN_EN_HI) begin
        main_en_q[GPIO_SRC] <= link.wdata[0];
      end
      if (link.addr == A_MAIN_EN_LO) begin
        main_en_q[7:0] <= link.wdata;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_en_q <= PIN_EN_RST;
    end else if (wr) begin
      if (link.addr == A_PIN_EN_HI) begin
        pin_en_q[23:16] <= link.wdata;
      end
      if (link.addr == A_PIN_EN_MID) begin
        pin_en_q[15:8] <= link.wdata;
      end
      if (link.addr == A_PIN_EN_LO) begin
        pin_en_q[7:0] <= link.wdata;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      icr_q <= ICR_RST;
    end else if (wr && link.addr == A_IRQ_CTRL) begin
      icr_q <= link.wdata[2:0];
    end
  end

  // ---------------------------------------------------------------
  // write-one-to-clear decode
  // ---------------------------------------------------------------
  always_comb begin
    pin_clr  = '0;
    main_clr = '0;
    if (wr) begin
      case (link.addr)
        A_PIN_STAT_HI:  pin_clr[23:16] = link.wdata;
        A_PIN_STAT_MID: pin_clr[15:8]  = link.wdata;
        A_PIN_STAT_LO:  pin_clr[7:0]   = link.wdata;
        A_MAIN_STAT_HI: main_clr[GPIO_SRC] = link.wdata[0];
        A_MAIN_STAT_LO: main_clr[7:0]  = link.wdata;
        default: begin
          pin_clr  = '0;
          main_clr = '0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // status banks
  // ---------------------------------------------------------------
  // masked pins still record, so software can poll them
  sticky_bank #(
    .W (PINS)
  ) u_pin_stat (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .set     (pin_event),
    .clr     (pin_clr),
    .q       (pin_stat)
  );

  // only enabled pins raise the gpio source
  assign gpio_hit = |(pin_event & pin_en_q);
  assign main_set = {gpio_hit, src_event};

  sticky_bank #(
    .W (SRCS)
  ) u_main_stat (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .set     (main_set),
    .clr     (main_clr),
    .q       (main_stat)
  );

  // ---------------------------------------------------------------
  // host pin
  // ---------------------------------------------------------------
  assign pending = |(main_stat & main_en_q);
  assign active  = pending & icr_q[ICR_MASK];
  assign trig    = icr_q[ICR_MASK] & |(main_set & main_en_q);

  // a new trigger during a running pulse is merged into it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_cnt_q <= 4'h0;
    end else if (ce) begin
      if (pulse_cnt_q != 4'h0) begin
        pulse_cnt_q <= pulse_cnt_q - 4'h1;
      end else if (trig && icr_q[ICR_EDGE]) begin
        pulse_cnt_q <= 4'(PULSE_LEN);
      end
    end
  end

  always_comb begin
    if (icr_q[ICR_EDGE]) begin
      assert_lvl = (pulse_cnt_q != 4'h0);
    end else begin
      assert_lvl = active;
    end
  end

  // polarity zero means active low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= IRQ_IDLE_RST;
    end else if (ce) begin
      irq_q <= icr_q[ICR_POL] ? assert_lvl : ~assert_lvl;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 8'h00;
    end else if (take && !link.we) begin
      case (link.addr)
        A_MAIN_STAT_HI: rdata_q <= {7'h00, main_stat[GPIO_SRC]};
        A_MAIN_STAT_LO: rdata_q <= main_stat[7:0];
        A_MAIN_EN_HI:   rdata_q <= {7'h00, main_en_q[GPIO_SRC]};
        A_MAIN_EN_LO:   rdata_q <= main_en_q[7:0];
        A_IRQ_CTRL:     rdata_q <= {5'h00, icr_q};
        A_PIN_EN_HI:    rdata_q <= pin_en_q[23:16];
        A_PIN_EN_MID:   rdata_q <= pin_en_q[15:8];
        A_PIN_EN_LO:    rdata_q <= pin_en_q[7:0];
        A_PIN_STAT_HI:  rdata_q <= pin_stat[23:16];
        A_PIN_STAT_MID: rdata_q <= pin_stat[15:8];
        A_PIN_STAT_LO:  rdata_q <= pin_stat[7:0];
        default:        rdata_q <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= take;
    end
  end

  assign link.ack     = ack_q;
  assign link.rdata   = rdata_q;
  assign link.irq_pin = irq_q;

endmodule
`default_nettype wire

// [design/irq_host.sv]
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module irq_host
  import irq_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  output logic             irq,
  irq_link_if.host         link
);
  typedef enum logic [6:0] {
    S_IDLE = 7'h01, S_INIT = 7'h02, S_RDMAIN = 7'h04, S_RDPIN = 7'h08,
    S_CLRPIN = 7'h10, S_CLRMAIN = 7'h20, S_OFF = 7'h40
  } state_t;
  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ---------------------------------------------------------------
  state_t          state_q;
  logic [2:0]      step_q;
  logic            dp_wr_q;
  logic [7:0]      dp_addr_q;
  logic [31:0]     hrdata_q;
  logic [SRCS-1:0] cfg_main_q;
  logic [PINS-1:0] cfg_pin_q;
  logic [2:0]      cfg_icr_q;
  logic [1:0]      cmd_q;
  logic [1:0]      cmd_set;
  logic [1:0]      cmd_clr;
  logic [EVENTS-1:0] ev_q, ev_set, ev_clr, ev_en_q;
  logic [SRCS-1:0] main_seen_q;
  logic [PINS-1:0] pin_seen_q;
  logic            req_q, we_q, act, act_q, svc_q, done, busy;
  logic [7:0]      addr_q, wdata_q, op_addr, op_wdata;
  logic            op_we;
  logic [2:0]      last;
  logic            start_svc;
  assign busy      = (state_q != S_IDLE);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  // hsize is ignored: only whole words are supported
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q   <= 1'b0;
      dp_addr_q <= 8'h00;
      hrdata_q  <= 32'h00000000;
    end else if (ce && hready) begin
      dp_wr_q   <= hsel & htrans[1] & hwrite;
      dp_addr_q <= haddr[7:0];
      case (haddr[7:0])
        H_MAIN_EN:   hrdata_q <= {23'h000000, cfg_main_q};
        H_PIN_EN:    hrdata_q <= {8'h00, cfg_pin_q};
        H_ICR:       hrdata_q <= {29'h00000000, cfg_icr_q};
        H_MAIN_SEEN: hrdata_q <= {busy, 22'h000000, main_seen_q};
        H_PIN_SEEN:  hrdata_q <= {8'h00, pin_seen_q};
        H_EV_STAT:   hrdata_q <= {28'h0000000, ev_q};
        H_EV_EN:     hrdata_q <= {28'h0000000, ev_en_q};
        default:     hrdata_q <= 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_main_q <= MAIN_EN_RST;
      cfg_pin_q  <= PIN_EN_RST;
      cfg_icr_q  <= ICR_RST;
      ev_en_q    <= '0;
    end else if (ce && dp_wr_q) begin
      if (dp_addr_q == H_MAIN_EN) cfg_main_q <= hwdata[SRCS-1:0];
      if (dp_addr_q == H_PIN_EN)  cfg_pin_q  <= hwdata[PINS-1:0];
      if (dp_addr_q == H_ICR)     cfg_icr_q  <= hwdata[2:0];
      if (dp_addr_q == H_EV_EN)   ev_en_q    <= hwdata[EVENTS-1:0];
    end
  end
  assign cmd_set = (ce && dp_wr_q && dp_addr_q == H_CMD) ? hwdata[1:0] : 2'h0;
  assign ev_clr  = (dp_wr_q && dp_addr_q == H_EV_CLR) ? hwdata[EVENTS-1:0] : '0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q <= 2'h0;
    end else if (ce) begin
      cmd_q <= (cmd_q & ~cmd_clr) | cmd_set;
    end
  end
  sticky_bank #(
    .W (EVENTS)
  ) u_ev (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .set     (ev_set),
    .clr     (ev_clr),
    .q       (ev_q)
  );
  assign irq = |(ev_q & ev_en_q);
  // ---------------------------------------------------------------
  // device pin watch
  // ---------------------------------------------------------------
  assign act = (link.irq_pin == cfg_icr_q[ICR_POL]);
  // level mode restarts on a still asserted pin, so nothing is missed
  // edge mode runs once per rise; level mode must not rerun on a stale rise
  assign start_svc = cfg_icr_q[ICR_EDGE] ? svc_q : act;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_q <= 1'b0;
      svc_q <= 1'b0;
    end else if (ce) begin
      act_q <= act;
      if (act && !act_q) svc_q <= 1'b1;
      else if (!busy && !cmd_q[CMD_OFF] && !cmd_q[CMD_INIT]) svc_q <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // transfer sequencer
  // ---------------------------------------------------------------
  always_comb begin
    op_addr  = 8'h00;
    op_we    = 1'b1;
    op_wdata = 8'h00;
    last     = 3'h0;
    case (state_q)
      S_INIT: begin
        last = 3'h5;
        case (step_q)
          3'h0: begin op_addr = A_MAIN_EN_HI; op_wdata = {7'h00, cfg_main_q[GPIO_SRC]}; end
          3'h1: begin op_addr = A_MAIN_EN_LO; op_wdata = cfg_main_q[7:0]; end
          3'h2: begin op_addr = A_PIN_EN_HI;  op_wdata = cfg_pin_q[23:16]; end
          3'h3: begin op_addr = A_PIN_EN_MID; op_wdata = cfg_pin_q[15:8]; end
          3'h4: begin op_addr = A_PIN_EN_LO;  op_wdata = cfg_pin_q[7:0]; end
          default: begin op_addr = A_IRQ_CTRL; op_wdata = {5'h00, cfg_icr_q}; end
        endcase
      end
      S_RDMAIN: begin
        last    = 3'h1;
        op_we   = 1'b0;
        op_addr = (step_q == 3'h0) ? A_MAIN_STAT_HI : A_MAIN_STAT_LO;
      end
      S_RDPIN: begin
        last    = 3'h2;
        op_we   = 1'b0;
        op_addr = 8'(A_PIN_STAT_HI + {5'h00, step_q});
      end
      S_CLRPIN: begin
        last     = 3'h2;
        op_addr  = 8'(A_PIN_STAT_HI + {5'h00, step_q});
        op_wdata = (step_q == 3'h0) ? pin_seen_q[23:16] :
                   (step_q == 3'h1) ? pin_seen_q[15:8] : pin_seen_q[7:0];
      end
      S_CLRMAIN: begin
        last     = 3'h1;
        op_addr  = (step_q == 3'h0) ? A_MAIN_STAT_HI : A_MAIN_STAT_LO;
        op_wdata = (step_q == 3'h0) ? {7'h00, main_seen_q[GPIO_SRC]}
                                    : main_seen_q[7:0];
      end
      S_OFF: begin
        op_addr  = A_IRQ_CTRL;
        op_wdata = {5'h00, cfg_icr_q & ~3'h1};
      end
      default: op_we = 1'b0;
    endcase
  end
  assign done    = req_q & link.ack & ce;
  assign cmd_clr = (!busy && cmd_q[CMD_OFF]) ? 2'h2 :
                   (!busy && cmd_q[CMD_INIT]) ? 2'h1 : 2'h0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= 1'b0; we_q <= 1'b0; addr_q <= 8'h00; wdata_q <= 8'h00;
    end else if (ce) begin
      if (done) begin
        req_q <= 1'b0;
      end else if (busy && !req_q) begin
        req_q <= 1'b1; we_q <= op_we; addr_q <= op_addr; wdata_q <= op_wdata;
      end
    end
  end
  always_comb begin
    ev_set = '0;
    if (done && step_q == last) begin
      ev_set[EV_INIT]  = (state_q == S_INIT);
      ev_set[EV_OFF]   = (state_q == S_OFF);
      ev_set[EV_GPIO]  = (state_q == S_CLRMAIN) & main_seen_q[GPIO_SRC];
      ev_set[EV_OTHER] = (state_q == S_CLRMAIN) & (|main_seen_q[7:0]);
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= S_IDLE; step_q <= 3'h0; main_seen_q <= '0; pin_seen_q <= '0;
    end else if (ce) begin
      case (state_q)
        S_IDLE: begin
          step_q <= 3'h0;
          if (cmd_q[CMD_OFF]) state_q <= S_OFF;
          else if (cmd_q[CMD_INIT]) state_q <= S_INIT;
          else if (start_svc) begin
            state_q <= S_RDMAIN; main_seen_q <= '0; pin_seen_q <= '0;
          end
        end
        default: if (done) begin
          if (state_q == S_RDMAIN && step_q == 3'h0) main_seen_q[GPIO_SRC] <= link.rdata[0];
          if (state_q == S_RDMAIN && step_q == 3'h1) main_seen_q[7:0] <= link.rdata;
          if (state_q == S_RDPIN) begin
            case (step_q)
              3'h0: pin_seen_q[23:16] <= link.rdata;
              3'h1: pin_seen_q[15:8]  <= link.rdata;
              default: pin_seen_q[7:0] <= link.rdata;
            endcase
          end
          step_q <= (step_q == last) ? 3'h0 : 3'(step_q + 3'h1);
          if (step_q == last) begin
            case (state_q)
              S_RDMAIN: state_q <= main_seen_q[GPIO_SRC] ? S_RDPIN : S_CLRMAIN;
              S_RDPIN:  state_q <= S_CLRPIN;
              S_CLRPIN: state_q <= S_CLRMAIN;
              default:  state_q <= S_IDLE;
            endcase
          end
        end
      endcase
    end
  end
  assign link.req   = req_q;
  assign link.we    = we_q;
  assign link.addr  = addr_q;
  assign link.wdata = wdata_q;
endmodule
`default_nettype wire

// [design/irq_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface irq_link_if;
  logic       req;
  logic       we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       ack;
  logic       irq_pin;
  modport device (input req, we, addr, wdata, output rdata, ack, irq_pin);
  modport host   (output req, we, addr, wdata, input rdata, ack, irq_pin);
endinterface
`default_nettype wire

// [design/irq_pkg.sv]
`default_nettype none
package irq_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ      = 20;
  localparam int PULSE_NS     = 250;
  localparam int PULSE_CYCLES = (PULSE_NS * CLK_MHZ + 999) / 1000;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int PINS     = 24;
  localparam int SRCS     = 9;
  localparam int GPIO_SRC = 8;
  localparam int EVENTS   = 4;
  // ---------------------------------------------------------------
  // device byte registers on the link
  // ---------------------------------------------------------------
  localparam logic [7:0] A_MAIN_STAT_HI = 8'h10;
  localparam logic [7:0] A_MAIN_STAT_LO = 8'h11;
  localparam logic [7:0] A_MAIN_EN_HI   = 8'h12;
  localparam logic [7:0] A_MAIN_EN_LO   = 8'h13;
  localparam logic [7:0] A_IRQ_CTRL     = 8'h14;
  localparam logic [7:0] A_PIN_EN_HI    = 8'h15;
  localparam logic [7:0] A_PIN_EN_MID   = 8'h16;
  localparam logic [7:0] A_PIN_EN_LO    = 8'h17;
  localparam logic [7:0] A_PIN_STAT_HI  = 8'h18;
  localparam logic [7:0] A_PIN_STAT_MID = 8'h19;
  localparam logic [7:0] A_PIN_STAT_LO  = 8'h1A;
  // irq_control_reg fields
  localparam int ICR_MASK = 0;
  localparam int ICR_EDGE = 1;
  localparam int ICR_POL  = 2;
  // reset values
  localparam logic [2:0]      ICR_RST      = 3'h0;
  localparam logic [SRCS-1:0] MAIN_EN_RST  = 9'h000;
  localparam logic [PINS-1:0] PIN_EN_RST   = 24'h000000;
  localparam logic            IRQ_IDLE_RST = 1'b1;
  // ---------------------------------------------------------------
  // host controller words on AHB-Lite
  // ---------------------------------------------------------------
  localparam logic [7:0] H_MAIN_EN   = 8'h00;
  localparam logic [7:0] H_PIN_EN    = 8'h04;
  localparam logic [7:0] H_ICR       = 8'h08;
  localparam logic [7:0] H_CMD       = 8'h0C;
  localparam logic [7:0] H_MAIN_SEEN = 8'h10;
  localparam logic [7:0] H_PIN_SEEN  = 8'h14;
  localparam logic [7:0] H_EV_STAT   = 8'h18;
  localparam logic [7:0] H_EV_CLR    = 8'h1C;
  localparam logic [7:0] H_EV_EN     = 8'h20;
  localparam int CMD_INIT = 0;
  localparam int CMD_OFF  = 1;
  localparam int EV_INIT  = 0;
  localparam int EV_GPIO  = 1;
  localparam int EV_OTHER = 2;
  localparam int EV_OFF   = 3;
endpackage
`default_nettype wire

// [design/sticky_bank.sv]
`timescale 1ns/1ps
`default_nettype none
module sticky_bank #(
  parameter int W = 8
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q
);
  // a set in the clearing cycle survives the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= (q & ~clr) | set;
    end
  end
endmodule
`default_nettype wire

// [tb/gpio_interrupt_status_logic_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    comparisons++; \
    if ((got) !== (ex)) begin \
      err_total++; \
      $display("wrong value %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module gpio_interrupt_status_logic_tb_top
  import irq_pkg::*;
;
  typedef struct packed {
    logic [2:0]  irq_control_reg;
    logic [23:0] pe;
    logic [7:0]  se;
    logic [8:0]  main;
    logic [23:0] pin;
    logic [3:0]  ev;
  } row_t;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        irq;
  logic        ce;
  logic [23:0] pin_event;
  logic [7:0]  src_event;
  int          err_total;
  int          comparisons;
  row_t        rows [5];
  assign hready = hreadyout;
  irq_link_if irq_link_if_inst ();
  irq_dev #(.PULSE_LEN(5)) irq_dev_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .pin_event(pin_event), .src_event(src_event), .link(irq_link_if_inst.device));
  irq_host irq_host_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .link(irq_link_if_inst.host));
  irq_link_asserts irq_link_asserts_inst (.hclk(hclk), .hresetn(hresetn),
    .req(irq_link_if_inst.req), .we(irq_link_if_inst.we), .addr(irq_link_if_inst.addr),
    .wdata(irq_link_if_inst.wdata), .rdata(irq_link_if_inst.rdata),
    .ack(irq_link_if_inst.ack), .irq_pin(irq_link_if_inst.irq_pin));
  // ---------------------------------------------------------------
  // bus and sequence tasks
  // ---------------------------------------------------------------
  task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(a, 1'b1, d, x);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] d;
    ahb(a, 1'b0, 32'h00000000, d);
    `CHK(nm, ex, d);
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    logic [31:0] d;
    int          n;
    n = 0;
    do begin
      ahb(a, 1'b0, 32'h00000000, d);
      n++;
    end while (d[b] !== v && n < 100);
    `CHK("poll bit", v, d[b]);
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge hclk);
      n++;
    end
    `CHK("irq", 1'b1, irq);
  endtask
  task automatic pulse(input logic [23:0] pe, input logic [7:0] se);
    pin_event <= pe;
    src_event <= se;
    @(posedge hclk);
    pin_event <= 24'h000000;
    src_event <= 8'h00;
  endtask
  task automatic setup(input logic [2:0] irq_control_reg);
    wr(H_ICR, {29'h0, irq_control_reg});
    wr(H_CMD, 32'h00000001);
    wait_irq;
    rd_chk("init event", H_EV_STAT, 32'h00000001);
    wr(H_EV_CLR, 32'h0000000F);
  endtask
  task automatic service(input row_t r);
    pulse(r.pe, r.se);
    wait_irq;
    poll(H_MAIN_SEEN, 31, 1'b0);
    rd_chk("events", H_EV_STAT, {28'h0, r.ev});
    rd_chk("main seen", H_MAIN_SEEN, {23'h0, r.main});
    rd_chk("pin seen", H_PIN_SEEN, {8'h00, r.pin});
    wr(H_EV_CLR, 32'h0000000F);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // clock, watchdog, tests
  // ---------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    stop_test;
  end
  initial begin
    err_total   = 0;
    comparisons = 0;
    hresetn = 1'b0;
    {hsel, haddr, htrans, hwrite, hwdata, pin_event, src_event} = '0;
    hsize = 3'b010;
    ce    = 1'b1;
    rows[0] = '{3'h1, 24'h000001, 8'h00, 9'h100, 24'h000001, 4'h2};
    rows[1] = '{3'h3, 24'h800000, 8'h00, 9'h100, 24'h800000, 4'h2};
    rows[2] = '{3'h5, 24'h000000, 8'h80, 9'h080, 24'h000000, 4'h4};
    rows[3] = '{3'h7, 24'h000000, 8'h01, 9'h001, 24'h000000, 4'h4};
    rows[4] = '{3'h3, 24'h000080, 8'h00, 9'h100, 24'h000080, 4'h2};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK("irq reset", 1'b0, irq);
    `CHK("pin idle", IRQ_IDLE_RST, irq_link_if_inst.irq_pin);
    rd_chk("icr reset", H_ICR, 32'h00000000);
    rd_chk("pin en reset", H_PIN_EN, 32'h00000000);
    rd_chk("unmapped", 8'h40, 32'h00000000);
    wr(H_MAIN_EN, 32'h000001F7);
    wr(H_PIN_EN, 32'h00FFFEFF);
    wr(H_EV_EN, 32'h0000000F);
    rd_chk("pin en", H_PIN_EN, 32'h00FFFEFF);
    $display("reset test done");
    foreach (rows[i]) begin
      setup(rows[i].irq_control_reg);
      service(rows[i]);
      $display("row %0d done", i);
    end
    // masked pin and disabled source record without signalling
    setup(3'h1);
    pulse(24'h000100, 8'h08);
    repeat (30) @(posedge hclk);
    `CHK("irq masked pin", 1'b0, irq);
    service('{3'h1, 24'h000200, 8'h00, 9'h108, 24'h000300, 4'h6});
    service('{3'h1, 24'h800000, 8'h00, 9'h100, 24'h800000, 4'h2});
    $display("enable test done");
    wr(H_EV_EN, 32'h00000007);
    wr(H_CMD, 32'h00000002);
    poll(H_EV_STAT, EV_OFF, 1'b1);
    `CHK("irq ev masked", 1'b0, irq);
    wr(H_EV_EN, 32'h0000000F);
    @(posedge hclk);
    `CHK("irq ev on", 1'b1, irq);
    wr(H_EV_CLR, 32'h00000008);
    @(posedge hclk);
    `CHK("irq ev clr", 1'b0, irq);
    pulse(24'h000001, 8'h00);
    repeat (30) @(posedge hclk);
    `CHK("pin off", 1'b1, irq_link_if_inst.irq_pin);
    `CHK("irq off", 1'b0, irq);
    ce <= 1'b0;
    wr(H_EV_EN, 32'h00000000);
    ce <= 1'b1;
    rd_chk("ce freeze", H_EV_EN, 32'h0000000F);
    $display("off test done");
    stop_test;
  end
endmodule
`default_nettype wire

// [tb/irq_link_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module irq_link_asserts
  import irq_pkg::*;
(
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       req,
  input wire logic       we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       ack,
  input wire logic       irq_pin
);
  // ---------------------------------------------------------------
  // shadow of the control byte
  // ---------------------------------------------------------------
  logic [2:0] ctrl_q;
  logic       pol_q;
  logic [3:0] since_wr_q;
  logic [3:0] off_cnt_q;
  logic       take;
  logic       act;
  assign take = req && !ack;
  // pin follows a control write one edge late, so polarity lags to match
  assign act  = (irq_pin == pol_q);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= ICR_RST;
      pol_q  <= 1'b0;
    end else begin
      if (take && we && addr == A_IRQ_CTRL) begin
        ctrl_q <= wdata[2:0];
      end
      pol_q <= ctrl_q[ICR_POL];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since_wr_q <= 4'hF;
    end else if (take && we) begin
      since_wr_q <= 4'h0;
    end else if (since_wr_q != 4'hF) begin
      since_wr_q <= since_wr_q + 4'h1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      off_cnt_q <= 4'h0;
    end else if (ctrl_q[ICR_MASK]) begin
      off_cnt_q <= 4'h0;
    end else if (off_cnt_q != 4'hF) begin
      off_cnt_q <= off_cnt_q + 4'h1;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ack_after_take_a: assert property (take |=> ack)
    else $error("no ack after link request");
  ack_single_a: assert property (ack |=> !ack && !req)
    else $error("ack longer than one cycle or request kept");
  req_held_a: assert property (take |=> req && $stable(addr) && $stable(we) && $stable(wdata))
    else $error("link request changed before ack");
  rdata_kept_a: assert property (!(take && !we) |=> $stable(rdata))
    else $error("read data changed without a read");
  pulse_width_a: assert property ($rose(act) && ctrl_q[ICR_EDGE] |-> act [*5] ##1 !act)
    else $error("edge pulse not five cycles");
  mask_quiet_a: assert property (off_cnt_q >= 4'd8 |-> !act)
    else $error("pin active while masked");
  rise_unmasked_a: assert property ($rose(act) |-> ctrl_q[ICR_MASK])
    else $error("pin asserted with mask off");
  level_release_a: assert property ($fell(act) && !ctrl_q[ICR_EDGE] |-> since_wr_q <= 4'd3)
    else $error("level pin released without a clear");
endmodule
`default_nettype wire
